// ==== tpr_timer_pair.v ====
/*
  Dual 8-bit timer pair with mode select: two 8-bit timers, one 16-bit timer,
  8-bit pulse generator, or 8-bit PWM plus 8-bit timer, with a toggle flip-flop.
  Assumes prescaler taps and the enable are one-cycle pulses on clk_i; the
  external clock is an asynchronous pin and is synchronised here.
  Selects and compare values are read live: change them only while stopped,
  or a period in flight may end early or run a full wrap.
*/
// Behaviour
// - Mode field selects two 8-bit timers, 16-bit timer, pulse generator, or PWM plus timer.
// - PWM period code 01,10,11 gives period 2^6-1, 2^7-1, 2^8-1.
// - Two-timer mode: high counter clocked by low match, tap a, c or d.
// - PWM mode: high counter clocked only from tap a, c or d.
// - Low counter clocked by external clock, tap a, b or c in every mode.
// - Two-timer mode: trigger select 0 toggles flip-flop from low, 1 from high.
// - PWM mode: flip-flop carries PWM; high counter still runs as 8-bit timer.
// - PWM mode: low match never clocks the high counter.
// - PWM mode: high counter has no timer output; pin driven by PWM only.
`timescale 1ns/10ps
`include "tpr_consts.vh"

module tpr_timer_pair #(
  parameter WIDTH = 8
) (
  input  wire             clk_i,          // 50 MHz clock
  input  wire             rstn_i,         // Async reset, active low
  input  wire             ce_i,           // Clock enable, freezes all state
  input  wire             run_i,          // Counters run; low clears them
  input  wire [1:0]       pair_mode_i,    // pair_mode_select
  input  wire [1:0]       pwm_period_i,   // PWM period select
  input  wire [1:0]       high_clk_sel_i, // high_clock_select
  input  wire [1:0]       low_clk_sel_i,  // low_clock_select
  input  wire             ff_trig_sel_i,  // ff_trigger_select
  input  wire             ff_toggle_en_i, // Toggling enabled
  input  wire             ff_clear_i,     // Clear flip-flop (pulse)
  input  wire [WIDTH-1:0] low_cmp_i,      // Low counter compare value
  input  wire [WIDTH-1:0] high_cmp_i,     // High counter compare value
  input  wire             ext_clk_i,      // External clock pin
  input  wire             tap_div_a_i,    // Prescaler tap a pulse
  input  wire             tap_div_b_i,    // Prescaler tap b pulse
  input  wire             tap_div_c_i,    // Prescaler tap c pulse
  input  wire             tap_div_d_i,    // Prescaler tap d pulse
  output reg  [WIDTH-1:0] low_count_o,    // Low counter value
  output reg  [WIDTH-1:0] high_count_o,   // High counter value
  output reg              low_match_o,    // Low match pulse
  output reg              high_match_o,   // High match pulse
  output reg              timer_ff_o      // Timer flip-flop output
);

  // ------------------------------------------------
  // External clock synchroniser and edge detect
  // ------------------------------------------------
  reg ext_s1_ff;
  reg ext_s2_ff;
  reg ext_s3_ff;
  // Third stage only feeds the edge detect; the tick follows the pin by two cycles
  wire ext_tick = ext_s2_ff & ~ext_s3_ff;

  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ext_s1_ff <= 1'h0;
      ext_s2_ff <= 1'h0;
      ext_s3_ff <= 1'h0;
    end else if (ce_i) begin
      ext_s1_ff <= ext_clk_i;
      ext_s2_ff <= ext_s1_ff;
      ext_s3_ff <= ext_s2_ff;
    end
  end

  // ------------------------------------------------
  // Mode decode and clock selection
  // ------------------------------------------------
  wire mode_2x8 = (pair_mode_i == `TPR_MODE_2X8);
  wire mode_16  = (pair_mode_i == `TPR_MODE_16);
  wire mode_ppg = (pair_mode_i == `TPR_MODE_PPG);
  wire mode_pwm = (pair_mode_i == `TPR_MODE_PWM);

  reg low_tick;
  reg high_tick;
  reg [WIDTH-1:0] pwm_top;
  wire low_hit;
  wire high_hit;

  always @* begin
    case (low_clk_sel_i)
      `TPR_CLK_SEL0: low_tick = ext_tick;
      `TPR_CLK_SEL1: low_tick = tap_div_a_i;
      `TPR_CLK_SEL2: low_tick = tap_div_b_i;
      default:       low_tick = tap_div_c_i;
    endcase
  end

  always @* begin
    case (high_clk_sel_i)
      // Low match is never a clock in PWM mode
      `TPR_CLK_SEL0: high_tick = mode_2x8 ? low_hit : 1'h0;
      `TPR_CLK_SEL1: high_tick = tap_div_a_i;
      `TPR_CLK_SEL2: high_tick = tap_div_c_i;
      default:       high_tick = tap_div_d_i;
    endcase
  end

  always @* begin
    // Period code 00 is unused; it falls back to the full 8-bit period
    case (pwm_period_i)
      `TPR_PWM_P6: pwm_top = `TPR_PWM_TOP6;
      `TPR_PWM_P7: pwm_top = `TPR_PWM_TOP7;
      default:     pwm_top = `TPR_PWM_TOP8;
    endcase
  end

  // ------------------------------------------------
  // Compare logic
  // ------------------------------------------------
  // 16-bit mode: high half advances on low overflow, match needs both halves
  wire low_eq  = (low_count_o == low_cmp_i);
  wire high_eq = (high_count_o == high_cmp_i);
  // PWM period is exactly top ticks, so the count runs 0 to top-1
  wire low_top = (low_count_o == pwm_top - 8'h01);
  wire low_ovf = low_tick & (&low_count_o);
  wire match16 = low_tick & low_eq & high_eq;
  assign low_hit  = low_tick & low_eq & ~mode_16;
  assign high_hit = mode_16 ? match16 : (high_tick & high_eq);

  // Pulse generator: low compare sets edge, high compare ends period
  wire ppg_end = low_tick & (low_count_o == high_cmp_i);
  wire pwm_end = low_tick & low_top;

  reg [WIDTH-1:0] nxt_low;
  reg [WIDTH-1:0] nxt_high;
  reg             nxt_ff;

  always @* begin
    nxt_low  = low_count_o;
    nxt_high = high_count_o;
    nxt_ff   = timer_ff_o;
    if (!run_i) begin
      nxt_low  = `TPR_RST_CNT;
      nxt_high = `TPR_RST_CNT;
    end else begin
      if (mode_16) begin
        if (match16) begin
          nxt_low  = `TPR_RST_CNT;
          nxt_high = `TPR_RST_CNT;
        end else if (low_tick) begin
          nxt_low  = low_count_o + 8'h01;
          if (low_ovf)
            nxt_high = high_count_o + 8'h01;
        end
      end else begin
        if (mode_pwm)
          nxt_low = pwm_end ? `TPR_RST_CNT : (low_tick ? low_count_o + 8'h01 : low_count_o);
        else if (mode_ppg)
          nxt_low = ppg_end ? `TPR_RST_CNT : (low_tick ? low_count_o + 8'h01 : low_count_o);
        // Two-timer mode: compare value is the last count before the wrap
        else if (low_tick)
          nxt_low = low_eq ? `TPR_RST_CNT : low_count_o + 8'h01;
        // High counter idles in pulse mode, serves as a timer otherwise
        if (!mode_ppg && high_tick)
          nxt_high = high_eq ? `TPR_RST_CNT : high_count_o + 8'h01;
      end
      // Toggle source depends on the mode; only PWM sets and clears directly
      if (ff_toggle_en_i) begin
        if (mode_pwm) begin
          // Waveform: set on low compare, clear at period end
          if (pwm_end)
            nxt_ff = 1'h0;
          else if (low_hit)
            nxt_ff = 1'h1;
        end else if (mode_ppg) begin
          if (low_hit | ppg_end)
            nxt_ff = ~timer_ff_o;
        end else if (mode_16) begin
          if (match16)
            nxt_ff = ~timer_ff_o;
        end else if (ff_trig_sel_i ? high_hit : low_hit) begin
          nxt_ff = ~timer_ff_o;
        end
      end
    end
    // Software clear beats a toggle in the same cycle
    if (ff_clear_i)
      nxt_ff = `TPR_RST_FF;
  end

  // ------------------------------------------------
  // Match pulses
  // ------------------------------------------------
  // Pulse mode keeps its high-side match quiet: the high counter idles there
  reg nxt_low_match;
  reg nxt_high_match;

  always @* begin
    nxt_low_match  = 1'h0;
    nxt_high_match = 1'h0;
    if (run_i) begin
      nxt_low_match  = low_hit | (mode_16 & match16);
      nxt_high_match = high_hit & ~mode_ppg;
    end
  end

  // ------------------------------------------------
  // State registers
  // ------------------------------------------------
  // All state holds while ce_i is low
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      low_count_o  <= `TPR_RST_CNT;
      high_count_o <= `TPR_RST_CNT;
      low_match_o  <= 1'h0;
      high_match_o <= 1'h0;
      timer_ff_o   <= `TPR_RST_FF;
    end else if (ce_i) begin
      low_count_o  <= nxt_low;
      high_count_o <= nxt_high;
      low_match_o  <= nxt_low_match;
      high_match_o <= nxt_high_match;
      timer_ff_o   <= nxt_ff;
    end
  end

endmodule

// ==== tpr_consts.vh ====
/*
  Constants for the dual 8-bit timer pair: mode codes, clock-select codes,
  PWM period codes and reset values.
  Assumes inclusion by bare name from the timer pair module.
*/
`ifndef TPR_CONSTS_VH
`define TPR_CONSTS_VH

// ------------------------------------------------
// Pair mode codes
// ------------------------------------------------
`define TPR_MODE_2X8   2'h0
`define TPR_MODE_16    2'h1
`define TPR_MODE_PPG   2'h2
`define TPR_MODE_PWM   2'h3

// ------------------------------------------------
// Clock select codes
// ------------------------------------------------
`define TPR_CLK_SEL0   2'h0
`define TPR_CLK_SEL1   2'h1
`define TPR_CLK_SEL2   2'h2
`define TPR_CLK_SEL3   2'h3

// ------------------------------------------------
// PWM period codes and terminal counts
// ------------------------------------------------
`define TPR_PWM_P6     2'h1
`define TPR_PWM_P7     2'h2
`define TPR_PWM_P8     2'h3
`define TPR_PWM_TOP6   8'h3F
`define TPR_PWM_TOP7   8'h7F
`define TPR_PWM_TOP8   8'hFF

// ------------------------------------------------
// Reset values
// ------------------------------------------------
`define TPR_RST_CNT    8'h00
`define TPR_RST_FF     1'h0

`endif

// ==== tpr_timer_pair_sva.sv ====
/* Port checker for the timer pair.
   Assumes binding onto tpr_timer_pair with one clock and async low reset. */
`timescale 1ns/10ps
`include "tpr_consts.vh"
module tpr_chk (
  input wire       clk_i,          // Clock
  input wire       rstn_i,         // Async reset, active low
  input wire       ce_i,           // Clock enable
  input wire       run_i,          // Run
  input wire       ff_trig_sel_i,  // Toggle source
  input wire       ff_toggle_en_i, // Toggle enable
  input wire       ff_clear_i,     // Flip-flop clear
  input wire       tap_div_a_i,    // Tap a
  input wire       tap_div_b_i,    // Tap b
  input wire       tap_div_c_i,    // Tap c
  input wire       tap_div_d_i,    // Tap d
  input wire [1:0] pair_mode_i,    // Mode
  input wire [1:0] pwm_period_i,   // PWM period code
  input wire [1:0] high_clk_sel_i, // High clock select
  input wire [1:0] low_clk_sel_i,  // Low clock select
  input wire [7:0] low_cmp_i,      // Low compare
  input wire [7:0] high_cmp_i,     // High compare
  input wire [7:0] low_count_o,    // Low count
  input wire [7:0] high_count_o,   // High count
  input wire       low_match_o,    // Low match pulse
  input wire       high_match_o,   // High match pulse
  input wire       timer_ff_o      // Flip-flop
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  wire go = ce_i && run_i;
  wire m03 = pair_mode_i[0] == pair_mode_i[1];
  wire lt = low_clk_sel_i == 1 ? tap_div_a_i : low_clk_sel_i == 2 ? tap_div_b_i : tap_div_c_i;
  wire ht = high_clk_sel_i == 1 ? tap_div_a_i : high_clk_sel_i == 2 ? tap_div_c_i : tap_div_d_i;
  wire ls = go && low_clk_sel_i != 0;
  // 16-bit and pulse modes never clock the high counter from its select, so high checks skip them
  wire hs = go && m03 && high_clk_sel_i != 0;
  wire [7:0] top = pwm_period_i == 1 ? `TPR_PWM_TOP6 : pwm_period_i == 2 ? `TPR_PWM_TOP7 : 8'hFF;
  sequence s_lmatch;
    pair_mode_i == 0 && ls && lt && low_count_o == low_cmp_i;
  endsequence
  sequence s_ltop;
    pair_mode_i == `TPR_MODE_PWM && ls && lt && low_count_o == top - 8'h01 && low_cmp_i != 0;
  endsequence
  AST_FREEZE: assert property (!ce_i |=> $stable(low_count_o) && $stable(timer_ff_o))
    else $error("state moved while frozen");
  AST_LOW_IDLE: assert property (ls && m03 && !lt |=> $stable(low_count_o))
    else $error("low counter moved without tick");
  AST_LOW_INC: assert property (pair_mode_i == 0 && ls && lt && low_count_o != low_cmp_i
    |=> low_count_o == $past(low_count_o) + 8'h01)
    else $error("low counter missed tick");
  AST_LOW_CLR: assert property (s_lmatch |=> low_count_o == 8'h00)
    else $error("low counter not cleared on match");
  AST_FF_TOG: assert property (s_lmatch ##0 (!ff_trig_sel_i && ff_toggle_en_i && !ff_clear_i)
    |=> timer_ff_o != $past(timer_ff_o))
    else $error("flip-flop missed low toggle");
  AST_PWM_TOP: assert property (s_ltop ##0 ff_toggle_en_i |=> low_count_o == 0 && !timer_ff_o)
    else $error("pwm period end wrong");
  AST_HIGH_NOLM: assert property (go && pair_mode_i == `TPR_MODE_PWM && high_clk_sel_i == 0
    |=> $stable(high_count_o))
    else $error("high counter clocked by low match");
  AST_HIGH_INC: assert property (hs && ht && high_count_o != high_cmp_i
    |=> high_count_o == $past(high_count_o) + 8'h01)
    else $error("high counter missed tick");
  AST_FF_CLR: assert property (ce_i && ff_clear_i |=> !timer_ff_o)
    else $error("flip-flop not cleared");
  AST_LOW_MPULSE: assert property (s_lmatch |=> low_match_o)
    else $error("low match pulse missing");
  AST_HIGH_MPULSE: assert property (hs && ht && high_count_o == high_cmp_i |=> high_match_o)
    else $error("high match pulse missing");
endmodule
bind tpr_timer_pair tpr_chk u_tpr_chk (.clk_i, .rstn_i, .ce_i, .run_i, .ff_trig_sel_i,
  .ff_toggle_en_i, .ff_clear_i, .tap_div_a_i, .tap_div_b_i, .tap_div_c_i, .tap_div_d_i,
  .pair_mode_i, .pwm_period_i, .high_clk_sel_i, .low_clk_sel_i, .low_cmp_i, .high_cmp_i,
  .low_count_o, .high_count_o, .low_match_o, .high_match_o, .timer_ff_o);

// ==== tpr_timer_pair_bench.sv ====
/* Self-checking bench for the timer pair, inputs driven at the falling edge.
   Assumes the checker is bound in; the external clock pin is driven here. */
`timescale 1ns/10ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin bad_count++; \
  $display("wrong value t=%0t got %h exp %h", $time, a, b); end end
module tpr_timer_pair_bench;
  logic       clk_i = 0, rstn_i = 0, ce_i = 1, run_i = 0, ext_clk_i = 0, ff_clear_i = 0;
  logic       ff_trig_sel_i = 0, ff_toggle_en_i = 1, low_match_o, high_match_o, timer_ff_o;
  logic [1:0] pair_mode_i = 0, pwm_period_i = 0, high_clk_sel_i = 0, low_clk_sel_i = 0;
  logic [7:0] low_cmp_i = 0, high_cmp_i = 0, low_count_o, high_count_o;
  logic [3:0] tap = 0;
  int         bad_count = 0, check_count = 0;
  tpr_timer_pair u_tpr_timer_pair (.clk_i, .rstn_i, .ce_i, .run_i, .pair_mode_i, .pwm_period_i,
    .high_clk_sel_i, .low_clk_sel_i, .ff_trig_sel_i, .ff_toggle_en_i, .ff_clear_i, .low_cmp_i,
    .high_cmp_i, .ext_clk_i, .tap_div_a_i(tap[0]), .tap_div_b_i(tap[1]), .tap_div_c_i(tap[2]),
    .tap_div_d_i(tap[3]), .low_count_o, .high_count_o, .low_match_o, .high_match_o, .timer_ff_o);
  initial forever #10 clk_i = ~clk_i;
  task pulse(input [3:0] t, input int n);
    repeat (n) begin tap = t; @(negedge clk_i); end
    tap = 0;
    // Idle edge so a following call never re-drives tap in the same step
    @(negedge clk_i);
  endtask
  // Stop and clear before each setup so every scenario starts from zero
  task cfg(input [1:0] m, ls, hs, input [7:0] lc, hc);
    {pair_mode_i, low_clk_sel_i, high_clk_sel_i, low_cmp_i, high_cmp_i} = {m, ls, hs, lc, hc};
    run_i = 0;
    ff_clear_i = 1;
    @(negedge clk_i);
    `CHK({low_count_o, high_count_o, timer_ff_o}, 17'h0)
    run_i = 1;
    ff_clear_i = 0;
  endtask
  task t_two8;
    for (int s = 1; s < 4; s++) begin
      cfg(0, 2'(s), 3, 8'h02, 8'h05);
      pulse(4'h1 << (s - 1), 2);
      `CHK(low_count_o, 8'h02)
      pulse(4'h1 << (s - 1), 1);
      `CHK({low_count_o, timer_ff_o}, 9'h001)
    end
    ff_trig_sel_i = 1;
    cfg(0, 1, 0, 8'h02, 8'h01);
    pulse(4'h1, 6);
    pulse(4'h0, 4);
    `CHK({high_count_o, timer_ff_o}, 9'h001)
    ff_trig_sel_i = 0;
    ff_toggle_en_i = 0;
    cfg(0, 1, 3, 8'h01, 8'h05);
    pulse(4'h1, 2);
    `CHK({low_count_o, timer_ff_o}, 9'h000)
    ff_toggle_en_i = 1;
    cfg(0, 0, 3, 8'h05, 8'h05);
    repeat (2) begin
      ext_clk_i = 1;
      repeat (3) @(negedge clk_i);
      ext_clk_i = 0;
      repeat (3) @(negedge clk_i);
    end
    `CHK(low_count_o, 8'h02)
    $display("two timers done");
  endtask
  task t_pwm;
    for (int p = 1; p < 4; p++) begin
      cfg(3, 1, 0, 8'h10, 8'h02);
      pwm_period_i = 2'(p);
      pulse(4'h1, (1 << (p + 5)) - 2);
      `CHK({low_count_o, high_count_o, timer_ff_o}, {8'((1 << (p + 5)) - 2), 9'h001})
      pulse(4'h1, 1);
      `CHK({low_count_o, high_count_o, timer_ff_o}, 17'h0)
    end
    high_clk_sel_i = 2;
    pulse(4'h4, 2);
    `CHK(high_count_o, 8'h02)
    pulse(4'h4, 1);
    `CHK({high_count_o, timer_ff_o}, 9'h000)
    $display("pwm done");
  endtask
  task t_wide;
    cfg(1, 1, 0, 8'h00, 8'h02);
    pulse(4'h1, 256);
    `CHK({high_count_o, low_count_o}, 16'h0100)
    ce_i = 0;
    pulse(4'h1, 3);
    `CHK({high_count_o, low_count_o}, 16'h0100)
    ce_i = 1;
    pulse(4'h1, 257);
    `CHK({high_count_o, low_count_o, timer_ff_o}, 17'h00001)
    $display("wide done");
  endtask
  task t_ppg;
    cfg(2, 1, 1, 8'h02, 8'h05);
    pulse(4'h1, 4);
    `CHK({high_count_o, low_count_o, timer_ff_o}, 17'h009)
    pulse(4'h1, 2);
    `CHK({low_count_o, timer_ff_o}, 9'h000)
    $display("pulse done");
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (6) @(negedge clk_i);
    rstn_i = 1;
    @(negedge clk_i);
    t_two8;
    t_pwm;
    t_wide;
    t_ppg;
    conclude;
  end
  // Whole run is under 2000 cycles; this limit only catches a hang
  initial begin
    #100000;
    bad_count++;
    conclude;
  end
endmodule
